// ==== verilog/dac_regs_pkg.sv ====
/*
 * Shared constants and types for the converter register block: register
 * byte offsets, field positions, reset values, trigger source codes, the
 * transfer sequencer states and the bus request carrier.
 * Assumes a 32-bit classic Wishbone bus with an 8-bit byte address.
 */
package dac_regs_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h00;
    localparam logic [7:0] OFS_SOFT_TRIGGER_CTRL = 8'h04;
    localparam logic [7:0] OFS_CH1_HOLD_12_RIGHT = 8'h08;
    localparam logic [7:0] OFS_CH1_HOLD_12_LEFT = 8'h0c;
    localparam logic [7:0] OFS_CH1_HOLD_8_RIGHT = 8'h10;
    localparam logic [7:0] OFS_CH2_HOLD_12_RIGHT = 8'h14;
    localparam logic [7:0] OFS_CH1_OUTPUT = 8'h2c;
    localparam logic [7:0] OFS_CH2_OUTPUT = 8'h30;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CHAN_COUNT = 2;
    localparam int CTRL_CH_STRIDE = 16;
    localparam int CTRL_TRIGGER_ON_POS = 2;
    localparam int CTRL_TRIGGER_SOURCE_POS = 3;
    localparam int SOFT_KICK_POS = 0;
    localparam int HOLD_LEFT_POS = 4;
    localparam int DATA_W = 12;
    localparam int NARROW_W = 8;
    localparam int SRC_COUNT = 8;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RESET_DATA = 12'h000;
    localparam logic [2:0] SRC_SOFTWARE = 3'h7;
    localparam logic [2:0] SRC_RESERVED = 3'h5;

    // Hold register layouts as seen from the bus
    typedef enum logic [1:0] {
        FMT_12_RIGHT = 2'h0,
        FMT_12_LEFT = 2'h1,
        FMT_8_RIGHT = 2'h2,
        FMT_NONE = 2'h3
    } hold_fmt_t;

    // Transfer sequencer, Gray coded along idle, wait, wait, wait
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_WAIT1 = 2'h1,
        SEQ_WAIT2 = 2'h3,
        SEQ_WAIT3 = 2'h2
    } seq_state_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    // State of one channel transfer unit
    typedef struct packed {
        seq_state_t seq;
        logic [DATA_W-1:0] out;
    } chan_state_t;

    // State of the register block
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [CHAN_COUNT-1:0] trigger_on;
        logic [CHAN_COUNT-1:0][2:0] trigger_source;
        logic [CHAN_COUNT-1:0] soft_kick;
        logic [CHAN_COUNT-1:0][DATA_W-1:0] hold;
    } regs_state_t;

endpackage

// ==== verilog/dac_hold_format.sv ====
/*
 * Maps one common 12-bit holding value onto the three bus layouts of a
 * hold register, both for readback and for byte-masked writes.
 * Assumes the caller picks the layout from the decoded address.
 */
`timescale 1ns/10ps
`default_nettype none

module dac_hold_format
    import dac_regs_pkg::*;
(
    input wire logic [DATA_W-1:0] value_i,
    input wire hold_fmt_t fmt_i,
    input wire logic [31:0] wdat_i,
    input wire logic [31:0] mask_i,
    output logic [31:0] rdat_o,
    output logic [DATA_W-1:0] next_value_o
);

    logic [31:0] merged;

    // Readback layout and byte-lane merge of the written word
    always_comb
    begin
        rdat_o = RESET_WORD;
        case (fmt_i)
            FMT_12_RIGHT: rdat_o[DATA_W-1:0] = value_i;
            FMT_12_LEFT: rdat_o[HOLD_LEFT_POS +: DATA_W] = value_i;
            FMT_8_RIGHT: rdat_o[NARROW_W-1:0] = value_i[DATA_W-1 -: NARROW_W];
            default: rdat_o = RESET_WORD;
        endcase
        merged = (rdat_o & ~mask_i) | (wdat_i & mask_i);
        case (fmt_i)
            FMT_12_RIGHT: next_value_o = merged[DATA_W-1:0];
            FMT_12_LEFT: next_value_o = merged[HOLD_LEFT_POS +: DATA_W];
            FMT_8_RIGHT: next_value_o = {merged[NARROW_W-1:0], 4'h0};
            default: next_value_o = value_i;
        endcase
    end

endmodule // dac_hold_format

`default_nettype wire

// ==== verilog/dac_chan_transfer.sv ====
/*
 * Transfer of one channel's holding value into its output register:
 * straight through when triggering is off, one cycle after a software
 * kick, three cycles after a selected hardware trigger pulse.
 * Assumes hardware trigger inputs are one-cycle pulses synchronous to clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module dac_chan_transfer
    import dac_regs_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic trigger_on_i,
    input wire logic [2:0] trigger_source_i,
    input wire logic soft_kick_i,
    input wire logic [SRC_COUNT-1:0] hw_trig_i,
    input wire logic [WIDTH-1:0] hold_i,
    output logic [WIDTH-1:0] output_o,
    output logic kick_done_o
);

    chan_state_t st;
    chan_state_t next_st;
    logic soft_sel;
    logic hw_fire;

    // ------------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------------
    assign soft_sel = trigger_source_i == SRC_SOFTWARE;
    assign hw_fire = hw_trig_i[trigger_source_i] && !soft_sel
        && trigger_source_i != SRC_RESERVED;
    assign kick_done_o = trigger_on_i && soft_sel && soft_kick_i;
    assign output_o = st.out;

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        if (!trigger_on_i)
        begin
            next_st.seq = SEQ_IDLE;
            next_st.out = hold_i;
        end
        else if (soft_sel)
        begin
            next_st.seq = SEQ_IDLE;
            if (soft_kick_i)
            begin
                next_st.out = hold_i;
            end
        end
        else
        begin
            case (st.seq)
                SEQ_IDLE: if (hw_fire) next_st.seq = SEQ_WAIT1;
                SEQ_WAIT1: next_st.seq = SEQ_WAIT2;
                SEQ_WAIT2: next_st.seq = SEQ_WAIT3;
                SEQ_WAIT3:
                begin
                    next_st.seq = SEQ_IDLE;
                    next_st.out = hold_i;
                end
                default: next_st.seq = SEQ_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '{seq: SEQ_IDLE, out: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule // dac_chan_transfer

`default_nettype wire

// ==== verilog/dac_regs.sv ====
/*
 * Register side of a two-channel converter: classic Wishbone slave with
 * the channel control word, the software trigger register, the three
 * channel-1 holding layouts, the channel-2 holding register and the
 * readable output registers, plus one transfer unit per channel.
 * Assumes a single clock, synchronous reset and a classic Wishbone master.
 */
// The Wishbone register port was chosen for this implementation.
// Contract
// - Bit 0 of trigger register: writing 1 requests channel-1 kick, 0 withdraws it.
// - Bit 1 of trigger register: writing 1 requests channel-2 kick, 0 withdraws it.
// - Channel-1 kick loads output from holding one cycle later, then clears itself.
// - Channel-2 kick loads output from holding one cycle later, then clears itself.
// - Channel-1 12-bit right-aligned data in bits 11:0, reset 0, rest reserved.
// - Channel-1 12-bit left-aligned data in bits 15:4, reset 0, rest reserved.
// - Channel-1 8-bit right-aligned data in bits 7:0, reset 0, rest reserved.
// - 3-bit source select picks the trigger when enabled; code 111 is software.
// - Triggering off: output follows in 1 cycle; on: 3 cycles after trigger.
// - With software source the holding-to-output transfer takes one cycle only.
`timescale 1ns/10ps
`default_nettype none

module dac_regs
    import dac_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [SRC_COUNT-1:0] ch1_hw_trig_i,
    input wire logic [SRC_COUNT-1:0] ch2_hw_trig_i,
    output logic [DATA_W-1:0] ch1_output_o,
    output logic [DATA_W-1:0] ch2_output_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    regs_state_t st;
    regs_state_t next_st;
    logic req_hit;
    logic commit;
    logic [31:0] mask;
    logic [31:0] merged;
    logic [31:0] rd_word;
    logic [31:0] fmt_rdat;
    logic [DATA_W-1:0] fmt_value;
    hold_fmt_t fmt;
    logic [CHAN_COUNT-1:0] kick_done;
    logic [CHAN_COUNT-1:0][SRC_COUNT-1:0] hw_trig;
    logic [CHAN_COUNT-1:0][DATA_W-1:0] out_val;

    // ------------------------------------------------------------------
    // Bus qualification
    // ------------------------------------------------------------------

    // Request seen; a write commits at the edge where ack is sampled high
    assign req_hit = wb_req_i.cyc && wb_req_i.stb;
    assign commit = req_hit && st.ack && wb_req_i.we;
    assign mask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
        {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    assign merged = (rd_word & ~mask) | (wb_req_i.dat & mask);

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdat;
    assign hw_trig[0] = ch1_hw_trig_i;
    assign hw_trig[1] = ch2_hw_trig_i;
    assign ch1_output_o = out_val[0];
    assign ch2_output_o = out_val[1];

    // ------------------------------------------------------------------
    // Hold layout selection
    // ------------------------------------------------------------------

    // Pick the channel-1 layout from the address
    always_comb
    begin
        case (wb_req_i.adr)
            OFS_CH1_HOLD_12_RIGHT: fmt = FMT_12_RIGHT;
            OFS_CH1_HOLD_12_LEFT: fmt = FMT_12_LEFT;
            OFS_CH1_HOLD_8_RIGHT: fmt = FMT_8_RIGHT;
            default: fmt = FMT_NONE;
        endcase
    end

    dac_hold_format u_ch1_format (
        .value_i(st.hold[0]),
        .fmt_i(fmt),
        .wdat_i(wb_req_i.dat),
        .mask_i(mask),
        .rdat_o(fmt_rdat),
        .next_value_o(fmt_value)
    );

    // ------------------------------------------------------------------
    // Readback decode
    // ------------------------------------------------------------------

    // Reserved bits and unmapped addresses read as zero
    always_comb
    begin
        rd_word = RESET_WORD;
        case (wb_req_i.adr)
            OFS_CHAN_CTRL:
            begin
                for (int i = 0; i < CHAN_COUNT; i++)
                begin
                    rd_word[CTRL_TRIGGER_ON_POS + i * CTRL_CH_STRIDE] = st.trigger_on[i];
                    rd_word[CTRL_TRIGGER_SOURCE_POS + i * CTRL_CH_STRIDE +: 3] =
                        st.trigger_source[i];
                end
            end
            OFS_SOFT_TRIGGER_CTRL: rd_word[SOFT_KICK_POS +: CHAN_COUNT] = st.soft_kick;
            OFS_CH1_HOLD_12_RIGHT: rd_word = fmt_rdat;
            OFS_CH1_HOLD_12_LEFT: rd_word = fmt_rdat;
            OFS_CH1_HOLD_8_RIGHT: rd_word = fmt_rdat;
            OFS_CH2_HOLD_12_RIGHT: rd_word[DATA_W-1:0] = st.hold[1];
            OFS_CH1_OUTPUT: rd_word[DATA_W-1:0] = out_val[0];
            OFS_CH2_OUTPUT: rd_word[DATA_W-1:0] = out_val[1];
            default: rd_word = RESET_WORD;
        endcase
    end

    // ------------------------------------------------------------------
    // Register next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;

        // One-cycle ack for every request, mapped or not
        next_st.ack = req_hit && !st.ack;
        next_st.rdat = (req_hit && !st.ack && !wb_req_i.we) ? rd_word : RESET_WORD;

        // Hardware clears a kick once its transfer has happened
        for (int i = 0; i < CHAN_COUNT; i++)
        begin
            if (kick_done[i])
            begin
                next_st.soft_kick[i] = 1'b0;
            end
        end

        // Software writes; a write in the clearing cycle wins
        if (commit)
        begin
            case (wb_req_i.adr)
                OFS_CHAN_CTRL:
                begin
                    for (int i = 0; i < CHAN_COUNT; i++)
                    begin
                        next_st.trigger_on[i] =
                            merged[CTRL_TRIGGER_ON_POS + i * CTRL_CH_STRIDE];
                        next_st.trigger_source[i] =
                            merged[CTRL_TRIGGER_SOURCE_POS + i * CTRL_CH_STRIDE +: 3];
                    end
                end
                OFS_SOFT_TRIGGER_CTRL:
                begin
                    next_st.soft_kick[0] = merged[SOFT_KICK_POS];
                    next_st.soft_kick[1] = merged[SOFT_KICK_POS + 1];
                end
                OFS_CH1_HOLD_12_RIGHT: next_st.hold[0] = fmt_value;
                OFS_CH1_HOLD_12_LEFT: next_st.hold[0] = fmt_value;
                OFS_CH1_HOLD_8_RIGHT: next_st.hold[0] = fmt_value;
                OFS_CH2_HOLD_12_RIGHT: next_st.hold[1] = merged[DATA_W-1:0];
                default: next_st.ack = 1'b0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel transfer units
    // ------------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < CHAN_COUNT; ch++)
        begin : g_chan
            dac_chan_transfer #(
                .WIDTH(DATA_W)
            ) u_transfer (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .trigger_on_i(st.trigger_on[ch]),
                .trigger_source_i(st.trigger_source[ch]),
                .soft_kick_i(st.soft_kick[ch]),
                .hw_trig_i(hw_trig[ch]),
                .hold_i(st.hold[ch]),
                .output_o(out_val[ch]),
                .kick_done_o(kick_done[ch])
            );
        end
    endgenerate

endmodule // dac_regs

`default_nettype wire

// ==== tb/dac_regs_properties.sv ====
/* Port checks for the converter register block.
   Assumes a classic Wishbone master and one clock with synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module dac_regs_checker
    import dac_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wb_req_t wb_req_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [SRC_COUNT-1:0] ch1_hw_trig_i,
    input wire logic [SRC_COUNT-1:0] ch2_hw_trig_i,
    input wire logic [DATA_W-1:0] ch1_output_o,
    input wire logic [DATA_W-1:0] ch2_output_o
);
    logic [2:0] quiet;
    logic rd_ack;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Read answer in progress
    assign rd_ack = wb_ack_o && !wb_req_i.we;
    // Cycles since the last event that may move the channel-1 output
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (wb_ack_o && wb_req_i.we) || (|ch1_hw_trig_i))
        begin
            quiet <= 3'h0;
        end
        else if (quiet != 3'h7)
        begin
            quiet <= quiet + 3'h1;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_answer;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_trig_res;
        rd_ack && wb_req_i.adr == OFS_SOFT_TRIGGER_CTRL |-> wb_dat_o[31:2] == 30'h0;
    endproperty
    a_trig_res: assert property (p_trig_res) else $error("trigger spare bits set");
    property p_r12_res;
        rd_ack && wb_req_i.adr == OFS_CH1_HOLD_12_RIGHT |-> wb_dat_o[31:12] == 20'h0;
    endproperty
    a_r12_res: assert property (p_r12_res) else $error("right 12 spare bits set");
    property p_l12_res;
        rd_ack && wb_req_i.adr == OFS_CH1_HOLD_12_LEFT
            |-> {wb_dat_o[31:16], wb_dat_o[3:0]} == 20'h0;
    endproperty
    a_l12_res: assert property (p_l12_res) else $error("left 12 spare bits set");
    property p_r8_res;
        rd_ack && wb_req_i.adr == OFS_CH1_HOLD_8_RIGHT |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_r8_res: assert property (p_r8_res) else $error("right 8 spare bits set");
    property p_out_still;
        quiet >= 3'h4 |-> $stable(ch1_output_o);
    endproperty
    a_out_still: assert property (p_out_still) else $error("output moved unprompted");
endmodule // dac_regs_checker
bind dac_regs dac_regs_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .ch1_hw_trig_i(ch1_hw_trig_i),
    .ch2_hw_trig_i(ch2_hw_trig_i), .ch1_output_o(ch1_output_o), .ch2_output_o(ch2_output_o));
`default_nettype wire

// ==== tb/wb_master_model.sv ====
/* Processor side of the register bus: classic Wishbone single cycles.
   Assumes the caller enters xfer just after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module wb_master_model
    import dac_regs_pkg::*;
(
    input wire logic clk_i,
    output var wb_req_t wb_req_o,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i
);
    // Bus idle from time zero
    initial
    begin
        wb_req_o = '0;
    end
    // One cycle: raise after an edge, hold until ack is sampled, then release
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk_i);
        wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_i !== 1'b1);
        rd = wb_dat_i;
        wb_req_o <= '0;
    endtask
endmodule // wb_master_model
`default_nettype wire

// ==== tb/tb_dac_regs.sv ====
/* Self-checking bench for the converter register block.
   Assumes the bus model and the bound port checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_dac_regs
    import dac_regs_pkg::*;
;
    logic clk_i;
    logic rst_i;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    wb_req_t wb_req_i;
    logic [SRC_COUNT-1:0] trig1;
    logic [DATA_W-1:0] ch1_out;
    logic [DATA_W-1:0] ch2_out;
    int bad_count;
    int n_compared;
    // Clock at 100 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    dac_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .ch1_hw_trig_i(trig1), .ch2_hw_trig_i(8'h00),
        .ch1_output_o(ch1_out), .ch2_output_o(ch2_out));
    wb_master_model bus_u (.clk_i(clk_i), .wb_req_o(wb_req_i), .wb_ack_i(wb_ack_o),
        .wb_dat_i(wb_dat_o));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus_u.xfer(1'b1, adr, dat, rd);
    endtask
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        bus_u.xfer(1'b0, adr, 32'h0, rd);
        chk(rd, exp);
    endtask
    // Both outputs keep the old value now and show the new one after one edge
    task automatic edge_chk(input logic [31:0] old, input logic [31:0] nxt);
        #1 chk({8'h00, ch2_out, ch1_out}, old);
        @(posedge clk_i);
        #1 chk({8'h00, ch2_out, ch1_out}, nxt);
    endtask
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog well beyond the hundred or so cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        end_of_test();
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        trig1 = 8'h00;
        bad_count = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 1; i < 5; i++)
            rdchk(8'(i * 4), 32'h0);
        // One value seen through all layouts, output follows with triggering off
        wr(OFS_CH1_HOLD_12_RIGHT, 32'hffff_fabc);
        edge_chk(32'h0000_0000, 32'h0000_0abc);
        rdchk(OFS_CH1_HOLD_12_RIGHT, 32'h0000_0abc);
        rdchk(OFS_CH1_HOLD_12_LEFT, 32'h0000_abc0);
        rdchk(OFS_CH1_HOLD_8_RIGHT, 32'h0000_00ab);
        wr(OFS_CH1_HOLD_12_LEFT, 32'hffff_5678);
        rdchk(OFS_CH1_HOLD_12_RIGHT, 32'h0000_0567);
        wr(OFS_CH1_HOLD_8_RIGHT, 32'hffff_ff9c);
        rdchk(OFS_CH1_HOLD_12_LEFT, 32'h0000_9c00);
        // Software source on both channels: new data waits for the kick
        wr(OFS_CHAN_CTRL, 32'h003c_003c);
        wr(OFS_CH1_HOLD_12_RIGHT, 32'h0000_0123);
        wr(OFS_CH2_HOLD_12_RIGHT, 32'h0000_0456);
        wr(OFS_SOFT_TRIGGER_CTRL, 32'h0000_0003);
        edge_chk(32'h0000_09c0, 32'h0045_6123);
        rdchk(OFS_SOFT_TRIGGER_CTRL, 32'h0);
        // Hardware source 0: kick bit is kept, unused, and can be withdrawn
        wr(OFS_CHAN_CTRL, 32'h0000_0004);
        wr(OFS_CH1_HOLD_12_RIGHT, 32'h0000_0777);
        wr(OFS_SOFT_TRIGGER_CTRL, 32'h0000_0001);
        rdchk(OFS_SOFT_TRIGGER_CTRL, 32'h1);
        wr(OFS_SOFT_TRIGGER_CTRL, 32'h0);
        rdchk(OFS_SOFT_TRIGGER_CTRL, 32'h0);
        // Hardware pulse reaches the output on the fourth edge
        trig1 <= 8'h01;
        @(posedge clk_i);
        trig1 <= 8'h00;
        repeat (2) @(posedge clk_i);
        edge_chk(32'h0045_6123, 32'h0045_6777);
        // Output register ignores writes, unmapped place reads zero
        wr(OFS_CH1_OUTPUT, 32'h0000_0fff);
        rdchk(OFS_CH1_OUTPUT, 32'h0000_0777);
        rdchk(8'h40, 32'h0);
        end_of_test();
    end
endmodule // tb_dac_regs
`default_nettype wire
